// [pkg/bld_pkg.sv]
// constants shared by the byte load group decoder
// assumes one processor clock and a byte stream from program memory
package bld_pkg;
  // prefix and fixed opcodes
  localparam logic [7:0] OP_PFX_EXT     = 8'hED;  // extended prefix
  localparam logic [7:0] OP_PFX_IX1     = 8'hDD;  // first index prefix
  localparam logic [7:0] OP_PFX_IX2     = 8'hFD;  // second index prefix
  localparam logic [7:0] OP_HOLE        = 8'h76;  // never a move
  localparam logic [7:0] OP_LOAD_A_CTR  = 8'h0A;  // acc from (counter_pair)
  localparam logic [7:0] OP_LOAD_A_SEC  = 8'h1A;  // acc from (second_pair)
  localparam logic [7:0] OP_ST_A_CTR    = 8'h02;  // acc to (counter_pair)
  localparam logic [7:0] OP_ST_A_SEC    = 8'h12;  // acc to (second_pair)
  localparam logic [7:0] OP_LOAD_A_ABS  = 8'h3A;  // acc from (nn)
  localparam logic [7:0] OP_ST_A_ABS    = 8'h32;  // acc to (nn)
  localparam logic [7:0] OP_IMM_MEM     = 8'h36;  // (pointer) or indexed <- n
  localparam logic [7:0] OP_A_FROM_IVEC = 8'h57;  // after extended prefix
  localparam logic [7:0] OP_A_FROM_REFR = 8'h5F;
  localparam logic [7:0] OP_IVEC_FROM_A = 8'h47;
  localparam logic [7:0] OP_REFR_FROM_A = 8'h4F;
  // field layout
  localparam logic [1:0] MOVE_TAG = 2'b01;  // bits 7:6 of a move
  localparam logic [1:0] IMM_TAG  = 2'b00;  // bits 7:6 of an immediate load
  localparam logic [2:0] MEM_CODE = 3'h6;   // register code meaning memory
  // operand selectors: 0..7 follow the register code, 6 is memory
  localparam logic [3:0] SEL_A    = 4'h7;
  localparam logic [3:0] SEL_MEM  = 4'h6;
  localparam logic [3:0] SEL_IVEC = 4'h8;  // interrupt vector base
  localparam logic [3:0] SEL_REFR = 4'h9;  // refresh counter
  localparam logic [3:0] SEL_IMM  = 4'hA;  // data byte of the instruction
  localparam logic [3:0] SEL_NONE = 4'hF;
  // instruction lengths
  localparam logic [2:0] LEN1 = 3'h1;
  localparam logic [2:0] LEN2 = 3'h2;
  localparam logic [2:0] LEN3 = 3'h3;
  localparam logic [2:0] LEN4 = 3'h4;
  // decoder states
  typedef enum logic [5:0] {
    ST_OPC   = 6'h01,  // expecting prefix or opcode
    ST_OPC2  = 6'h02,  // expecting opcode after a prefix
    ST_DISP  = 6'h04,  // expecting displacement
    ST_IMM   = 6'h08,  // expecting data byte
    ST_ADDLO = 6'h10,  // expecting low address byte
    ST_ADDHI = 6'h20   // expecting high address byte
  } bld_state_t;
endpackage

// [rtl/bld_decoder.sv]
// byte load group decoder: walks the instruction byte stream and
// reports operands, length, memory address and data of each load
// assumes program memory bytes arrive on i_clock with a valid strobe
`timescale 1ns/1ns

// Behaviour
// - move is 01dddsss; 7F and 40 included
// - 70-75 and 77 store register into (pointer_pair)
// - 0A/1A load acc, 02/12 store acc
// - ED 57/5F read, ED 47/4F write
// - 00ddd110 then data byte is immediate load
// - DD/FD prefix indexed, three bytes total
// - displacement directly follows the opcode
// - DD/FD 36 d n is four bytes
// - 3A reads, 32 writes absolute address
// - absolute address arrives low byte first
// - pointer_pair contents are the operand address
// - opcode taken in opcode fetch cycle
// - signed displacement added to index register
module bld_decoder
  import bld_pkg::*;
(
  input  wire logic        i_clock,             // processor clock
  input  wire logic        i_rst,               // sync reset, high
  input  wire logic        i_byte_valid,        // instruction byte present
  input  wire logic [7:0]  i_byte,              // instruction byte
  input  wire logic [15:0] i_pointer_pair,      // pointer pair contents
  input  wire logic [15:0] i_counter_pair,      // counter pair contents
  input  wire logic [15:0] i_second_pair,       // second pair contents
  input  wire logic [15:0] i_first_index_reg,   // first index register
  input  wire logic [15:0] i_second_index_reg,  // second index register
  output logic             o_opcode_fetch_cycle, // next byte is an opcode
  output logic             o_done,              // one-cycle end of instruction
  output logic             o_is_load,           // instruction is a byte load
  output logic [3:0]       o_dst_sel,           // destination selector
  output logic [3:0]       o_src_sel,           // source selector
  output logic [15:0]      o_addr,              // memory operand address
  output logic [7:0]       o_data,              // immediate data byte
  output logic [2:0]       o_length             // bytes in the instruction
);

  bld_state_t  state_q, state_d;   // byte position
  logic [7:0]  op_q,    op_d;      // prefix, then opcode
  logic        idx2_q,  idx2_d;    // second index register chosen
  logic        fetch_q, fetch_d;   // opcode fetch cycle flag
  logic        done_q,  done_d;
  logic        load_q,  load_d;
  logic [3:0]  dst_q,   dst_d;
  logic [3:0]  src_q,   src_d;
  logic [15:0] addr_q,  addr_d;
  logic [7:0]  data_q,  data_d;
  logic [2:0]  len_q,   len_d;
  logic [15:0] idx_base;           // chosen index register
  logic        idx_mem_move;       // exactly one side is memory

  assign idx_base     = idx2_q ? i_second_index_reg : i_first_index_reg;
  assign idx_mem_move = (i_byte[7:6] == MOVE_TAG) && (i_byte != OP_HOLE) &&
                        ((i_byte[5:3] == MEM_CODE) != (i_byte[2:0] == MEM_CODE));

  // next-state decode; without a valid byte only done clears and a corrupt state code recovers
  always_comb begin
    state_d = state_q;
    op_d    = op_q;
    idx2_d  = idx2_q;
    done_d  = 1'b0;
    load_d  = load_q;
    dst_d   = dst_q;
    src_d   = src_q;
    addr_d  = addr_q;
    data_d  = data_q;
    len_d   = len_q;
    if (i_byte_valid) begin
      case (state_q)
        ST_OPC: begin
          op_d   = i_byte;
          load_d = 1'b1;
          len_d  = LEN1;
          dst_d  = SEL_NONE;
          src_d  = SEL_NONE;
          data_d = 8'h00;
          addr_d = 16'h0000;
          if (i_byte == OP_PFX_EXT || i_byte == OP_PFX_IX1 || i_byte == OP_PFX_IX2) begin
            idx2_d  = (i_byte == OP_PFX_IX2);
            state_d = ST_OPC2;
          end else if (i_byte[7:6] == MOVE_TAG && i_byte != OP_HOLE) begin
            // register moves and pointer-indirect forms
            dst_d  = {1'b0, i_byte[5:3]};
            src_d  = {1'b0, i_byte[2:0]};
            addr_d = i_pointer_pair;
            done_d = 1'b1;
          end else if (i_byte == OP_LOAD_A_CTR || i_byte == OP_ST_A_CTR) begin
            dst_d  = (i_byte == OP_LOAD_A_CTR) ? SEL_A : SEL_MEM;
            src_d  = (i_byte == OP_LOAD_A_CTR) ? SEL_MEM : SEL_A;
            addr_d = i_counter_pair;
            done_d = 1'b1;
          end else if (i_byte == OP_LOAD_A_SEC || i_byte == OP_ST_A_SEC) begin
            dst_d  = (i_byte == OP_LOAD_A_SEC) ? SEL_A : SEL_MEM;
            src_d  = (i_byte == OP_LOAD_A_SEC) ? SEL_MEM : SEL_A;
            addr_d = i_second_pair;
            done_d = 1'b1;
          end else if (i_byte[7:6] == IMM_TAG && i_byte[2:0] == MEM_CODE) begin
            dst_d   = {1'b0, i_byte[5:3]};
            src_d   = SEL_IMM;
            addr_d  = i_pointer_pair;       // used only when dst is memory
            len_d   = LEN2;
            state_d = ST_IMM;
          end else if (i_byte == OP_LOAD_A_ABS || i_byte == OP_ST_A_ABS) begin
            dst_d   = (i_byte == OP_LOAD_A_ABS) ? SEL_A : SEL_MEM;
            src_d   = (i_byte == OP_LOAD_A_ABS) ? SEL_MEM : SEL_A;
            len_d   = LEN3;
            state_d = ST_ADDLO;
          end else begin
            load_d = 1'b0;
            done_d = 1'b1;
          end
        end
        ST_OPC2: begin
          len_d = LEN2;
          if (op_q == OP_PFX_EXT) begin
            done_d  = 1'b1;
            state_d = ST_OPC;
            case (i_byte)
              OP_A_FROM_IVEC: begin
                dst_d = SEL_A;
                src_d = SEL_IVEC;
              end
              OP_A_FROM_REFR: begin
                dst_d = SEL_A;
                src_d = SEL_REFR;
              end
              OP_IVEC_FROM_A: begin
                dst_d = SEL_IVEC;
                src_d = SEL_A;
              end
              OP_REFR_FROM_A: begin
                dst_d = SEL_REFR;
                src_d = SEL_A;
              end
              default: load_d = 1'b0;
            endcase
          end else if (i_byte == OP_IMM_MEM || idx_mem_move) begin
            // indexed forms; displacement comes next
            op_d    = i_byte;
            dst_d   = {1'b0, i_byte[5:3]};
            src_d   = (i_byte == OP_IMM_MEM) ? SEL_IMM : {1'b0, i_byte[2:0]};
            len_d   = LEN3;
            state_d = ST_DISP;
          end else begin
            load_d  = 1'b0;
            done_d  = 1'b1;
            state_d = ST_OPC;
          end
        end
        ST_DISP: begin
          // wraps modulo 64K like the address bus
          addr_d = idx_base + {{8{i_byte[7]}}, i_byte};
          if (op_q == OP_IMM_MEM) begin
            len_d   = LEN4;
            state_d = ST_IMM;
          end else begin
            done_d  = 1'b1;
            state_d = ST_OPC;
          end
        end
        ST_IMM: begin
          data_d  = i_byte;
          done_d  = 1'b1;
          state_d = ST_OPC;
        end
        ST_ADDLO: begin
          addr_d[7:0] = i_byte;
          state_d     = ST_ADDHI;
        end
        ST_ADDHI: begin
          addr_d[15:8] = i_byte;
          done_d       = 1'b1;
          state_d      = ST_OPC;
        end
        default: state_d = ST_OPC;
      endcase
    end else if (!(state_q inside {ST_OPC, ST_OPC2, ST_DISP, ST_IMM, ST_ADDLO, ST_ADDHI})) begin
      state_d = ST_OPC;  // recover from a corrupt state code
    end
    fetch_d = (state_d == ST_OPC) || (state_d == ST_OPC2);
  end

  // sequencing state
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_q <= ST_OPC;
      op_q    <= 8'h00;
      idx2_q  <= 1'b0;
      fetch_q <= 1'b1;
      done_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      op_q    <= op_d;
      idx2_q  <= idx2_d;
      fetch_q <= fetch_d;
      done_q  <= done_d;
    end
  end

  // decoded result, held until the first byte of the next instruction is taken
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      load_q <= 1'b0;
      dst_q  <= SEL_NONE;
      src_q  <= SEL_NONE;
      addr_q <= 16'h0000;
      data_q <= 8'h00;
      len_q  <= LEN1;
    end else begin
      load_q <= load_d;
      dst_q  <= dst_d;
      src_q  <= src_d;
      addr_q <= addr_d;
      data_q <= data_d;
      len_q  <= len_d;
    end
  end

  assign o_opcode_fetch_cycle = fetch_q;
  assign o_done               = done_q;
  assign o_is_load            = load_q;
  assign o_dst_sel            = dst_q;
  assign o_src_sel            = src_q;
  assign o_addr               = addr_q;
  assign o_data               = data_q;
  assign o_length             = len_q;

  // checks
  sequence s_first(logic [7:0] b);
    state_q == ST_OPC && i_byte_valid && i_byte == b;
  endsequence

  property p_move;
    @(posedge i_clock) disable iff (i_rst)
    state_q == ST_OPC && i_byte_valid && i_byte[7:6] == MOVE_TAG && i_byte != OP_HOLE |=>
      o_done && o_is_load && o_length == LEN1 && o_dst_sel == {1'b0, $past(i_byte[5:3])} &&
      o_src_sel == {1'b0, $past(i_byte[2:0])};
  endproperty
  a_move: assert property (p_move) else $error("move decode wrong");

  property p_hole;
    @(posedge i_clock) disable iff (i_rst) s_first(OP_HOLE) |=> o_done && !o_is_load;
  endproperty
  a_hole: assert property (p_hole) else $error("76 taken as load");

  property p_ind_store;
    @(posedge i_clock) disable iff (i_rst)
    state_q == ST_OPC && i_byte_valid && i_byte[7:3] == 5'h0E && i_byte != OP_HOLE |=>
      o_dst_sel == SEL_MEM && o_addr == $past(i_pointer_pair);
  endproperty
  a_ind_store: assert property (p_ind_store) else $error("pointer store wrong");

  property p_ctr_pair;
    @(posedge i_clock) disable iff (i_rst)
    s_first(OP_LOAD_A_CTR) |=> o_dst_sel == SEL_A && o_src_sel == SEL_MEM &&
      o_addr == $past(i_counter_pair);
  endproperty
  a_ctr_pair: assert property (p_ctr_pair) else $error("counter pair load wrong");

  property p_ext;
    @(posedge i_clock) disable iff (i_rst)
    s_first(OP_PFX_EXT) ##1 (i_byte_valid && i_byte == OP_A_FROM_REFR) |=>
      o_done && o_is_load && o_length == LEN2 && o_src_sel == SEL_REFR;
  endproperty
  a_ext: assert property (p_ext) else $error("refresh read wrong");

  property p_imm;
    logic [7:0] n;
    @(posedge i_clock) disable iff (i_rst)
    s_first(8'h3E) ##1 (i_byte_valid, n = i_byte) |=>
      o_done && o_length == LEN2 && o_data == n && o_dst_sel == SEL_A;
  endproperty
  a_imm: assert property (p_imm) else $error("immediate load wrong");

  property p_ix;
    logic [7:0] d;
    @(posedge i_clock) disable iff (i_rst)
    s_first(OP_PFX_IX1) ##1 (i_byte_valid && i_byte == 8'h7E) ##1 (i_byte_valid, d = i_byte) |=>
      o_done && o_length == LEN3 && o_addr == 16'($past(i_first_index_reg) + {{8{d[7]}}, d});
  endproperty
  a_ix: assert property (p_ix) else $error("indexed address wrong");

  property p_ix_imm;
    logic [7:0] n;
    @(posedge i_clock) disable iff (i_rst)
    s_first(OP_PFX_IX2) ##1 (i_byte_valid && i_byte == OP_IMM_MEM) ##1 i_byte_valid
      ##1 (i_byte_valid, n = i_byte) |=> o_done && o_length == LEN4 && o_data == n;
  endproperty
  a_ix_imm: assert property (p_ix_imm) else $error("indexed immediate wrong");

  property p_abs;
    logic [7:0] lo;
    @(posedge i_clock) disable iff (i_rst)
    s_first(OP_LOAD_A_ABS) ##1 (i_byte_valid, lo = i_byte) ##1 i_byte_valid |=>
      o_done && o_length == LEN3 && o_addr == {$past(i_byte), lo};
  endproperty
  a_abs: assert property (p_abs) else $error("absolute address wrong");

  property p_fetch;
    @(posedge i_clock) disable iff (i_rst) o_done |-> o_opcode_fetch_cycle;
  endproperty
  a_fetch: assert property (p_fetch) else $error("no opcode fetch after end");

endmodule

// [sim/bld_prog_mem.sv]
// program memory model: streams instruction bytes into the decoder
// assumes the bench calls send from one process, one call at a time
`timescale 1ns/1ns
module bld_prog_mem (
  input  wire logic       i_clock,      // processor clock
  input  wire logic       i_fetch,      // decoder expects an opcode next
  output logic            o_byte_valid, // byte on the bus
  output logic      [7:0] o_byte        // instruction byte
);
  logic fetch_seen [4];  // opcode flag seen beside each byte

  // bus idle at time zero
  initial begin
    o_byte_valid = 1'b0;
    o_byte       = 8'h00;
  end

  // idle cycle: data inverted so a stale byte never passes for a new one
  task automatic idle();
    @(posedge i_clock);
    #1;
    o_byte_valid = 1'b0;
    o_byte       = ~o_byte;
  endtask

  // n bytes with gap idle cycles between them; returns once the last is taken
  task automatic send(input logic [7:0] b0, b1, b2, b3, input int n, input int gap);
    logic [7:0] b [4];
    b = '{b0, b1, b2, b3};
    for (int i = 0; i < n; i++) begin
      @(posedge i_clock);
      #1;
      o_byte_valid  = 1'b1;
      o_byte        = b[i];
      fetch_seen[i] = i_fetch;
      if (i < n - 1) begin
        repeat (gap) idle();  // slow memory: decoder must freeze
      end
    end
    idle();
  endtask
endmodule

// [sim/tb.sv]
// self-checking bench for the byte load group decoder
// assumes the program memory model in bld_prog_mem and one 125 MHz clock
`timescale 1ns/1ns
module tb
  import bld_pkg::*;
;
  localparam logic [7:0] Z = 8'h00;  // unused byte slot
  logic        i_clock = 1'b0;       // processor clock
  logic        i_rst   = 1'b1;       // sync reset
  logic [15:0] ptr     = 16'h1234;   // pointer pair
  logic [15:0] ctr     = 16'h5A01;   // counter pair
  logic [15:0] sec     = 16'hA502;   // second pair
  logic [15:0] ix1     = 16'h0040;   // first index register
  logic [15:0] ix2     = 16'hFFC0;   // second index register
  wire         bvalid;               // byte strobe from memory
  wire  [7:0]  bbyte;                // byte from memory
  wire         fetch, done, is_load;
  wire  [3:0]  dst_sel, src_sel;
  wire  [15:0] addr;
  wire  [7:0]  data;
  wire  [2:0]  length;
  int          miscompares     = 0;  // mismatches seen
  int          samples_checked = 0;  // comparisons made

  // 8 ns period
  always #4 i_clock = ~i_clock;

  bld_decoder dut_u (.i_clock(i_clock), .i_rst(i_rst), .i_byte_valid(bvalid),
    .i_byte(bbyte), .i_pointer_pair(ptr), .i_counter_pair(ctr), .i_second_pair(sec),
    .i_first_index_reg(ix1), .i_second_index_reg(ix2), .o_opcode_fetch_cycle(fetch),
    .o_done(done), .o_is_load(is_load), .o_dst_sel(dst_sel), .o_src_sel(src_sel),
    .o_addr(addr), .o_data(data), .o_length(length));
  bld_prog_mem mem_u (.i_clock(i_clock), .i_fetch(fetch), .o_byte_valid(bvalid),
    .o_byte(bbyte));

  // compare and count
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // run one instruction and judge the report in its done cycle
  task automatic exec(input logic [7:0] b0, b1, b2, b3, input int n, input int gap,
                      input logic exp_load, input logic [3:0] dst, src, input logic ca,
                      input logic [15:0] ea, input logic [7:0] ed, input logic [2:0] len);
    mem_u.send(b0, b1, b2, b3, n, gap);
    check("done", 16'(done), 16'h0001);
    check("is_load", 16'(is_load), 16'(exp_load));
    check("length", 16'(length), 16'(len));
    if (exp_load) begin
      check("dst", 16'(dst_sel), 16'(dst));
      check("src", 16'(src_sel), 16'(src));
      check("data", 16'(data), 16'(ed));
      if (ca) begin
        check("addr", addr, ea);
      end
    end
    @(posedge i_clock);
    #1;
    check("done pulse", 16'(done), 16'h0000);
  endtask

  // reset held ten cycles, then idle state
  task automatic t_reset();
    repeat (10) @(posedge i_clock);
    #1;
    i_rst = 1'b0;
    check("fetch at reset", 16'(fetch), 16'h0001);
    check("done at reset", 16'(done), 16'h0000);
  endtask

  // every 01dddsss code, the hole at 76 included
  task automatic t_moves();
    logic [7:0] op;
    for (int k = 8'h40; k <= 8'h7F; k++) begin
      op  = 8'(k);
      ptr = {8'hC0, op};  // fresh pointer each time so a stale sample shows
      if (op == OP_HOLE) begin
        exec(op, Z, Z, Z, 1, 0, 1'b0, SEL_NONE, SEL_NONE, 1'b0, 16'h0000, Z, LEN1);
      end else begin
        exec(op, Z, Z, Z, 1, 0, 1'b1, {1'b0, op[5:3]}, {1'b0, op[2:0]},
             (op[5:3] == MEM_CODE) || (op[2:0] == MEM_CODE), ptr, Z, LEN1);
      end
    end
  endtask

  // accumulator through counter and second pairs
  task automatic t_pairs();
    exec(OP_LOAD_A_CTR, Z, Z, Z, 1, 0, 1'b1, SEL_A, SEL_MEM, 1'b1, ctr, Z, LEN1);
    exec(OP_LOAD_A_SEC, Z, Z, Z, 1, 0, 1'b1, SEL_A, SEL_MEM, 1'b1, sec, Z, LEN1);
    exec(OP_ST_A_CTR, Z, Z, Z, 1, 0, 1'b1, SEL_MEM, SEL_A, 1'b1, ctr, Z, LEN1);
    exec(OP_ST_A_SEC, Z, Z, Z, 1, 0, 1'b1, SEL_MEM, SEL_A, 1'b1, sec, Z, LEN1);
  endtask

  // special registers after the extended prefix, plus an unlisted code
  task automatic t_special();
    exec(OP_PFX_EXT, OP_A_FROM_IVEC, Z, Z, 2, 1, 1'b1, SEL_A, SEL_IVEC,
         1'b0, 16'h0000, Z, LEN2);
    exec(OP_PFX_EXT, OP_A_FROM_REFR, Z, Z, 2, 0, 1'b1, SEL_A, SEL_REFR,
         1'b0, 16'h0000, Z, LEN2);
    exec(OP_PFX_EXT, OP_IVEC_FROM_A, Z, Z, 2, 0, 1'b1, SEL_IVEC, SEL_A,
         1'b0, 16'h0000, Z, LEN2);
    exec(OP_PFX_EXT, OP_REFR_FROM_A, Z, Z, 2, 2, 1'b1, SEL_REFR, SEL_A,
         1'b0, 16'h0000, Z, LEN2);
    exec(OP_PFX_EXT, Z, Z, Z, 2, 0, 1'b0, SEL_NONE, SEL_NONE, 1'b0, 0, Z, LEN2);
  endtask

  // immediate loads of all eight targets, even codes with a stalled data byte
  task automatic t_immediate();
    logic [2:0] k;
    for (int i = 0; i < 8; i++) begin
      k = 3'(i);
      exec({2'b00, k, 3'b110}, 8'h5A ^ 8'(i), Z, Z, 2, 1 - i % 2, 1'b1, {1'b0, k},
           SEL_IMM, k == MEM_CODE, ptr, 8'h5A ^ 8'(i), LEN2);
    end
  endtask

  // both index registers at both ends of the displacement range
  task automatic t_indexed();
    logic [7:0]  pre, dv;
    logic [15:0] ea;
    for (int i = 0; i < 4; i++) begin
      pre = i[1] ? OP_PFX_IX2 : OP_PFX_IX1;
      dv  = i[0] ? 8'h7F : 8'h80;
      ea  = (i[1] ? ix2 : ix1) + {{8{dv[7]}}, dv};  // wraps modulo 2^16
      exec(pre, 8'h7E, dv, Z, 3, i, 1'b1, SEL_A, SEL_MEM, 1'b1, ea, Z, LEN3);
      exec(pre, 8'h70, dv, Z, 3, 0, 1'b1, SEL_MEM, 4'h0, 1'b1, ea, Z, LEN3);
      exec(pre, OP_IMM_MEM, dv, 8'hC3, 4, 3 - i, 1'b1, SEL_MEM, SEL_IMM, 1'b1, ea,
           8'hC3, LEN4);
      check("fetch at disp", 16'(mem_u.fetch_seen[2]), 16'h0000);
      check("fetch at data", 16'(mem_u.fetch_seen[3]), 16'h0000);
      exec(pre, 8'h40, Z, Z, 2, 0, 1'b0, SEL_NONE, SEL_NONE, 1'b0, 0, Z, LEN2);
    end
  endtask

  // absolute address, low byte first, with a slow memory on the store
  task automatic t_absolute();
    exec(OP_LOAD_A_ABS, 8'h32, 8'h6F, Z, 3, 0, 1'b1, SEL_A, SEL_MEM, 1'b1,
         16'h6F32, Z, LEN3);
    check("fetch at opcode", 16'(mem_u.fetch_seen[0]), 16'h0001);
    check("fetch at low", 16'(mem_u.fetch_seen[1]), 16'h0000);
    check("fetch at high", 16'(mem_u.fetch_seen[2]), 16'h0000);
    exec(OP_ST_A_ABS, 8'hCD, 8'hAB, Z, 3, 2, 1'b1, SEL_MEM, SEL_A, 1'b1,
         16'hABCD, Z, LEN3);
  endtask

  // reset in mid-instruction; the next byte must be taken as an opcode
  task automatic t_mid_reset();
    mem_u.send(OP_LOAD_A_ABS, 8'h11, Z, Z, 2, 0);
    i_rst = 1'b1;
    @(posedge i_clock);
    #1;
    i_rst = 1'b0;
    check("fetch after reset", 16'(fetch), 16'h0001);
    check("is_load after reset", 16'(is_load), 16'h0000);
    check("dst after reset", 16'(dst_sel), 16'(SEL_NONE));
    exec(8'h78, Z, Z, Z, 1, 0, 1'b1, SEL_A, 4'h0, 1'b0, 16'h0000, Z, LEN1);
  endtask

  // main sequence
  initial begin
    t_reset();
    t_moves();
    t_pairs();
    t_special();
    t_immediate();
    t_indexed();
    t_absolute();
    t_mid_reset();
    tally_and_finish();
  end

  // watchdog: the tests need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge i_clock);
    miscompares++;
    tally_and_finish();
  end
endmodule
